/* pkg/dcfwf_defines.vh */
// Purpose: Shared constants of the 18-bit flagged FIFO block
// Assumes: Included by bare name from every design file
// Notes:   Definitions only
`ifndef DCFWF_DEFINES_VH
`define DCFWF_DEFINES_VH

// ==========================================================
// Data path
`define DCFWF_DATA_W        18
`define DCFWF_ADDR_W_DEF    12

// ==========================================================
// Flag offset register reset values
`define DCFWF_AE_OFS_RESET  12'h007
`define DCFWF_AF_OFS_RESET  12'h007

// ==========================================================
// Bus register byte addresses
`define DCFWF_REG_CTRL      8'h00
`define DCFWF_REG_STATUS    8'h04
`define DCFWF_REG_OFFSETS   8'h08

// ==========================================================
// Control register fields
`define DCFWF_CTRL_SYNC_BIT 0
`define DCFWF_CTRL_CASC_BIT 1
`define DCFWF_CTRL_RESET    2'h0

// ==========================================================
// Status register fields
`define DCFWF_ST_EMPTY_BIT  0
`define DCFWF_ST_FULL_BIT   1
`define DCFWF_ST_AE_BIT     2
`define DCFWF_ST_AF_BIT     3
`define DCFWF_ST_HF_BIT     4
`define DCFWF_ST_WTOK_BIT   5
`define DCFWF_ST_RTOK_BIT   6
`define DCFWF_ST_LVL_LSB    16

`endif

/* rtl/dcfwf_mem.v */
// Purpose: Storage array of the FIFO, one write and one read port
// Assumes: Single clock; read address decoded without a clock
// Notes:   The top registers the read word before it leaves the block
`timescale 1ns/1ns
`default_nettype none
`include "dcfwf_defines.vh"

module dcfwf_mem #(
   parameter ADDR_W = `DCFWF_ADDR_W_DEF
) (
   // Clock
   input  wire                        ref_clk,
   input  wire                        clkEn,
   // Write port
   input  wire                        wrDo,
   input  wire [ADDR_W-1:0]           wrAddr,
   input  wire [`DCFWF_DATA_W-1:0]    wrData,
   // Read port
   input  wire [ADDR_W-1:0]           rdAddr,
   output wire [`DCFWF_DATA_W-1:0]    rdData
);

   reg [`DCFWF_DATA_W-1:0] store [0:(1<<ADDR_W)-1];

   always @(posedge ref_clk) begin
      if (clkEn && wrDo) begin
         store[wrAddr] <= wrData;
      end
   end

   assign rdData = store[rdAddr];

endmodule
`default_nettype wire

/* rtl/dcfwf_ahb_regs.v */
// Purpose: AHB-Lite slave with control, status and offset views
// Assumes: Zero wait states, single word transfers, OKAY always
// Notes:   Unmapped addresses read as zero and ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "dcfwf_defines.vh"

module dcfwf_ahb_regs (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        clkEn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Block state
   input  wire [31:0] statusWord,
   input  wire [31:0] offsetWord,
   output reg  [1:0]  ctrl
);

   reg       wrPend;
   reg [7:0] wrAddr;
   wire      take = hsel && htrans[1] && hready;

   always @(posedge ref_clk) begin
      if (reset) begin
         wrPend    <= 1'b0;
         wrAddr    <= 8'h00;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         ctrl      <= `DCFWF_CTRL_RESET;
      end else if (clkEn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend    <= take && hwrite;
         wrAddr    <= haddr;
         if (wrPend && wrAddr == `DCFWF_REG_CTRL) begin
            ctrl <= hwdata[1:0];
         end
         // Read data is ready for the data phase
         if (take && !hwrite) begin
            case (haddr)
               `DCFWF_REG_CTRL:    hrdata <= {30'h0000_0000, ctrl};
               `DCFWF_REG_STATUS:  hrdata <= statusWord;
               `DCFWF_REG_OFFSETS: hrdata <= offsetWord;
               default:            hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* rtl/dcfwf_top.v */
// Purpose: 18-bit FIFO with empty, full, half and programmable flags
// Assumes: Writer and reader share ref_clk; all pins are synchronous
// Notes:   Cascade tokens pass through the expansion pins
`timescale 1ns/1ns
`default_nettype none
`include "dcfwf_defines.vh"

module dcfwf_top #(
   parameter ADDR_W = `DCFWF_ADDR_W_DEF
) (
   // Clock, reset, clock enable
   input  wire                        ref_clk,
   input  wire                        reset,
   input  wire                        clkEn,
   input  wire                        device_reset_n,
   // Write port
   // eighteen-bit buses
   input  wire                        writeEnable_n,
   input  wire [`DCFWF_DATA_W-1:0]    dataIn,
   // Read port
   input  wire                        readEnable_n,
   input  wire                        outputEnable_n,
   output reg  [`DCFWF_DATA_W-1:0]    dataOut,
   output reg                         dataOutEn,
   // Mode pins
   input  wire                        offset_access_select,
   input  wire                        first_load_select,
   input  wire                        retransmit_strobe,
   // Cascade
   input  wire                        write_cascade_in,
   input  wire                        read_cascade_in,
   output reg                         read_cascade_out,
   // Flags
   output reg                         empty_flag_n,
   output reg                         full_flag_n,
   output reg                         almost_empty_flag_n,
   output reg                         almost_full_flag_n,
   output reg                         half_full_flag_n,
   // AHB-Lite slave
   input  wire                        hsel,
   input  wire [7:0]                  haddr,
   input  wire [1:0]                  htrans,
   input  wire                        hwrite,
   input  wire [2:0]                  hsize,
   input  wire                        hready,
   input  wire [31:0]                 hwdata,
   output wire [31:0]                 hrdata,
   output wire                        hreadyout,
   output wire                        hresp
);

   localparam [ADDR_W:0]   DEPTH    = {1'b1, {ADDR_W{1'b0}}};
   localparam [ADDR_W:0]   HALF     = {2'b01, {(ADDR_W-1){1'b0}}};
   localparam [ADDR_W-1:0] LAST_LOC = {ADDR_W{1'b1}};
   // Offset reset values are 12 bits; trimmed on purpose to the depth
   localparam [11:0]       AE_RST   = `DCFWF_AE_OFS_RESET;
   localparam [11:0]       AF_RST   = `DCFWF_AF_OFS_RESET;

   // ==========================================================
   // Fill level from two pointers that carry a wrap bit
   function [ADDR_W:0] levelOf;
      input [ADDR_W:0] w;
      input [ADDR_W:0] r;
      begin
         levelOf = w - r;
      end
   endfunction

   // ==========================================================
   // State
   reg  [ADDR_W:0]          wrPtr;
   reg  [ADDR_W:0]          rdPtr;
   reg  [ADDR_W-1:0]        aeOffset;
   reg  [ADDR_W-1:0]        afOffset;
   reg                      ofsWrSel;
   reg                      ofsRdSel;
   reg                      hasWrToken;
   reg                      hasRdToken;
   wire [1:0]               ctrl;
   wire                     syncFlags = ctrl[`DCFWF_CTRL_SYNC_BIT];
   wire                     cascaded  = ctrl[`DCFWF_CTRL_CASC_BIT];
   wire                     clear     = reset || !device_reset_n;
   wire [`DCFWF_DATA_W-1:0] memRd;

   // ==========================================================
   // Request qualification
   wire [ADDR_W:0] level   = levelOf(wrPtr, rdPtr);
   wire            isFull  = (level == DEPTH);
   wire            isEmpty = (level == {(ADDR_W+1){1'b0}});
   wire            dataSel = offset_access_select;
   wire wrDo = !writeEnable_n && dataSel && !isFull
             && (!cascaded || hasWrToken);
   wire rdDo = !readEnable_n && dataSel && !isEmpty
             && (!cascaded || hasRdToken);
   wire rtDo = retransmit_strobe && !cascaded;

   wire [ADDR_W:0] next_wrPtr = wrDo ? wrPtr + 1'b1 : wrPtr;
   wire [ADDR_W:0] next_rdPtr = rtDo ? {(ADDR_W+1){1'b0}}
                              : (rdDo ? rdPtr + 1'b1 : rdPtr);
   wire [ADDR_W:0] next_level = levelOf(next_wrPtr, next_rdPtr);

   wire wrLast = wrDo && cascaded && (wrPtr[ADDR_W-1:0] == LAST_LOC);
   wire rdLast = rdDo && cascaded && (rdPtr[ADDR_W-1:0] == LAST_LOC);

   // ==========================================================
   // Storage
   dcfwf_mem #(
      .ADDR_W (ADDR_W)
   ) u_mem (
      .ref_clk (ref_clk),
      .clkEn   (clkEn),
      .wrDo    (wrDo),
      .wrAddr  (wrPtr[ADDR_W-1:0]),
      .wrData  (dataIn),
      .rdAddr  (rdPtr[ADDR_W-1:0]),
      .rdData  (memRd)
   );

   // ==========================================================
   // Pointers, offsets and cascade tokens
   // both ports one clock
   always @(posedge ref_clk) begin
      if (clear) begin
         wrPtr      <= {(ADDR_W+1){1'b0}};
         rdPtr      <= {(ADDR_W+1){1'b0}};
         ofsWrSel   <= 1'b0;
         ofsRdSel   <= 1'b0;
         aeOffset   <= AE_RST[ADDR_W-1:0];
         afOffset   <= AF_RST[ADDR_W-1:0];
         hasWrToken <= !first_load_select;
         hasRdToken <= !first_load_select;
      end else if (clkEn) begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         if (!offset_access_select && !writeEnable_n) begin
            ofsWrSel <= !ofsWrSel;
            if (ofsWrSel) begin
               afOffset <= dataIn[ADDR_W-1:0];
            end else begin
               aeOffset <= dataIn[ADDR_W-1:0];
            end
         end
         if (!offset_access_select && !readEnable_n) begin
            ofsRdSel <= !ofsRdSel;
         end
         // Token arrives on the input strobe, leaves after last slot
         if (!write_cascade_in) begin
            hasWrToken <= 1'b1;
         end else if (wrLast) begin
            hasWrToken <= 1'b0;
         end
         if (!read_cascade_in) begin
            hasRdToken <= 1'b1;
         end else if (rdLast) begin
            hasRdToken <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Data output and flags
   always @(posedge ref_clk) begin
      if (clear) begin
         dataOut             <= {`DCFWF_DATA_W{1'b0}};
         dataOutEn           <= 1'b0;
         read_cascade_out    <= 1'b1;
         empty_flag_n        <= 1'b0;
         full_flag_n         <= 1'b1;
         almost_empty_flag_n <= 1'b0;
         almost_full_flag_n  <= 1'b1;
         half_full_flag_n    <= 1'b1;
      end else if (clkEn) begin
         dataOutEn <= !outputEnable_n;
         if (rdDo) begin
            dataOut <= memRd;
         end else if (!offset_access_select && !readEnable_n) begin
            dataOut <= {{(`DCFWF_DATA_W-ADDR_W){1'b0}},
                        ofsRdSel ? afOffset : aeOffset};
         end
         read_cascade_out <= !rdLast;
         empty_flag_n <= (next_level != {(ADDR_W+1){1'b0}});
         full_flag_n  <= (next_level != DEPTH);
         almost_empty_flag_n <= syncFlags
            ? (level > {1'b0, aeOffset})
            : (next_level > {1'b0, aeOffset});
         almost_full_flag_n <= syncFlags
            ? (level < DEPTH - {1'b0, afOffset})
            : (next_level < DEPTH - {1'b0, afOffset});
         // shared half full or cascade out
         half_full_flag_n <= cascaded ? !wrLast : (next_level <= HALF);
      end
   end

   // ==========================================================
   // Register bus
   wire [31:0] statusWord;
   wire [31:0] offsetWord;
   assign statusWord = {{(16-ADDR_W-1){1'b0}}, level, 9'h000,
                        hasRdToken, hasWrToken, half_full_flag_n,
                        almost_full_flag_n, almost_empty_flag_n,
                        full_flag_n, empty_flag_n};
   assign offsetWord = {{(16-ADDR_W){1'b0}}, afOffset,
                        {(16-ADDR_W){1'b0}}, aeOffset};

   dcfwf_ahb_regs u_regs (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .clkEn      (clkEn),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hready     (hready),
      .hwdata     (hwdata),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .statusWord (statusWord),
      .offsetWord (offsetWord),
      .ctrl       (ctrl)
   );

endmodule
`default_nettype wire

/* tb/dcfwf_checker.sv */
// Purpose: Pin-level assertions for the flagged FIFO
// Assumes: One clock domain, sync reset
// Notes:   Bound into dcfwf_top at the foot
`timescale 1ns/1ns
`default_nettype none
module dcfwf_checker #(parameter ADDR_W = 12) (
   // Clock and resets
   input wire logic        ref_clk,
   input wire logic        reset,
   input wire logic        device_reset_n,
   // Controls
   input wire logic        writeEnable_n,
   input wire logic        readEnable_n,
   input wire logic        outputEnable_n,
   input wire logic        offset_access_select,
   input wire logic        retransmit_strobe,
   // Outputs
   input wire logic [17:0] dataOut,
   input wire logic        dataOutEn,
   input wire logic        empty_flag_n,
   input wire logic        full_flag_n,
   input wire logic        almost_empty_flag_n,
   input wire logic        almost_full_flag_n,
   input wire logic        half_full_flag_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   wire logic wrGo = !writeEnable_n && offset_access_select && device_reset_n;
   wire logic noRt = !retransmit_strobe && device_reset_n;
   // ==========================================================
   // Assertions
   chk_reset_out:
      assert property ($fell(reset) |-> !empty_flag_n && dataOut == 18'h00000)
      else $error("state after reset wrong");
   chk_write_fills:
      assert property (!empty_flag_n && wrGo |=> empty_flag_n)
      else $error("write left buffer empty");
   chk_full_holds:
      assert property (!full_flag_n && readEnable_n && noRt |=> !full_flag_n)
      else $error("full cleared without read");
   chk_empty_holds:
      assert property (!empty_flag_n && writeEnable_n && noRt |=> !empty_flag_n)
      else $error("empty cleared without write");
   chk_oe_delay:
      assert property (!$past(reset) && $past(device_reset_n)
         |-> dataOutEn == !$past(outputEnable_n))
      else $error("output drive wrong");
   chk_half_nonempty:
      assert property (!half_full_flag_n |-> empty_flag_n)
      else $error("half flag while empty");
   chk_ae_at_empty:
      assert property (!empty_flag_n && $past(!empty_flag_n) |-> !almost_empty_flag_n)
      else $error("almost empty flag off");
   chk_af_at_full:
      assert property (!full_flag_n && $past(!full_flag_n) |-> !almost_full_flag_n)
      else $error("almost full flag off");
   cover property (!full_flag_n);
   cover property (retransmit_strobe && empty_flag_n);
   cover property (!offset_access_select && !readEnable_n);
endmodule
bind dcfwf_top dcfwf_checker #(.ADDR_W(ADDR_W)) chk (.ref_clk, .reset,
   .device_reset_n, .writeEnable_n, .readEnable_n, .outputEnable_n,
   .offset_access_select, .retransmit_strobe, .dataOut, .dataOutEn,
   .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .almost_full_flag_n,
   .half_full_flag_n);
`default_nettype wire

/* tb/dcfwf_partner.sv */
// Purpose: Writer and reader logic facing the FIFO ports
// Assumes: Requests change just after a clock edge
// Notes:   Idle data lines toggle every cycle
`timescale 1ns/1ns
`default_nettype none
module dcfwf_partner (
   // Clock and reset
   input wire logic         ref_clk,
   input wire logic         reset,
   // Requests
   input wire logic         wrReq,
   input wire logic         rdReq,
   input wire logic [17:0]  wrWord,
   // FIFO pins
   output logic             writeEnable_n,
   output logic             readEnable_n,
   output logic [17:0]      dataIn
);
   logic [17:0] lastWord = 18'h00000;
   assign writeEnable_n = reset | ~wrReq;
   assign readEnable_n = reset | ~rdReq;
   assign dataIn = wrReq ? wrWord : ~lastWord;
   always @(posedge ref_clk) begin
      lastWord <= dataIn;
   end
endmodule
`default_nettype wire

/* tb/dcfwf_bench.sv */
// Purpose: Self-checking bench of the flagged FIFO
// Assumes: Both ports on ref_clk, depth 64
// Notes:   Random traffic from a fixed seed plus corner cases
`timescale 1ns/1ns
`default_nettype none
module dcfwf_bench;
   localparam AW = 6;
   localparam DEPTH = 64;
   logic ref_clk = 1'h0, reset = 1'h1, device_reset_n = 1'h1;
   logic outputEnable_n = 1'h0, offset_access_select = 1'h1;
   logic retransmit_strobe = 1'h0, wrReq = 1'h0, rdReq = 1'h0;
   logic hsel = 1'h0, hwrite = 1'h0, syncMode = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] haddr = 8'h00;
   logic [17:0] wrWord = 18'h00000;
   logic [31:0] hwdata = 32'h00000000;
   logic [31:0] hrdata, rd;
   logic [17:0] dataIn, dataOut;
   logic writeEnable_n, readEnable_n, dataOutEn, read_cascade_out;
   logic empty_flag_n, full_flag_n, almost_empty_flag_n;
   logic almost_full_flag_n, half_full_flag_n, hreadyout, hresp;
   wire logic [4:0] flagVec = {half_full_flag_n, almost_full_flag_n,
      almost_empty_flag_n, full_flag_n, empty_flag_n};
   logic [17:0] mem [0:DEPTH-1];
   integer wp, rp, lvl, aeOfs, afOfs, i;
   integer mismatches = 0;
   integer n_checks = 0;

   initial forever #4 ref_clk = ~ref_clk;

   dcfwf_partner far (.ref_clk, .reset, .wrReq, .rdReq, .wrWord,
      .writeEnable_n, .readEnable_n, .dataIn);
   dcfwf_top #(.ADDR_W(AW)) uut (.ref_clk, .reset, .clkEn(1'h1),
      .device_reset_n, .writeEnable_n, .dataIn, .readEnable_n,
      .outputEnable_n, .dataOut, .dataOutEn, .offset_access_select,
      .first_load_select(1'h0), .retransmit_strobe,
      .write_cascade_in(1'h0), .read_cascade_in(1'h0), .read_cascade_out,
      .empty_flag_n, .full_flag_n, .almost_empty_flag_n,
      .almost_full_flag_n, .half_full_flag_n, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
      .hresp);

   // ==========================================================
   // Expectations and checks
   function automatic logic [4:0] expFlags(input integer l);
      return {l <= DEPTH / 2, l < DEPTH - afOfs, l > aeOfs, l != DEPTH, l != 0};
   endfunction
   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'h1) begin
         mismatches++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask
   task clearModel;
      wp = 0;
      rp = 0;
      lvl = 0;
   endtask
   // One cycle of writer and reader requests, then model update
   task step(input logic w, input logic r, input logic [17:0] d);
      logic rok, wok;
      logic [4:0] eNow, ePrev;
      integer prev;
      wrReq <= w;
      rdReq <= r;
      wrWord <= d;
      @(posedge ref_clk);
      #1;
      rok = r && lvl != 0 && offset_access_select;
      wok = w && lvl != DEPTH && offset_access_select;
      if (rok) chk(dataOut === mem[rp], "read word");
      if (rok) rp = (rp + 1) % DEPTH;
      if (wok) mem[wp] = d;
      if (wok) wp = (wp + 1) % DEPTH;
      prev = lvl;
      lvl = lvl + wok - rok;
      eNow = expFlags(lvl);
      ePrev = expFlags(prev);
      // Sync mode: almost flags follow the level seen before the edge
      if (syncMode) eNow[3:2] = ePrev[3:2];
      if (offset_access_select) chk(flagVec === eNow, "flags");
      chk(read_cascade_out === 1'h1, "cascade out idle");
   endtask
   // ==========================================================
   // Bus master
   task waitRdy;
      integer k;
      k = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'h1 && k < 99) begin
         k++;
         @(posedge ref_clk);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      waitRdy;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy;
      rd = hrdata;
      chk(hresp === 1'h0 && hreadyout === 1'h1, "bus response");
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #100000;
      mismatches++;
      results;
   end

   // ==========================================================
   // Tests
   initial begin
      aeOfs = 7;
      afOfs = 7;
      i = $urandom(52);
      clearModel;
      repeat (4) @(posedge ref_clk);
      reset <= 1'h0;
      @(posedge ref_clk);
      #1;
      chk(flagVec === expFlags(0), "reset flags");
      chk(dataOut === 18'h00000, "reset data");
      $display("test reset done");
      for (i = 0; i <= DEPTH; i++) step(1'h1, 1'h0, 18'($urandom));
      for (i = 0; i <= DEPTH; i++) step(1'h0, 1'h1, 18'h00000);
      chk(dataOut === mem[DEPTH - 1], "empty read");
      $display("test fill and drain done");
      for (i = 0; i < 300; i++) step(1'($urandom), 1'($urandom), 18'($urandom));
      $display("test random traffic done");
      outputEnable_n <= 1'h1;
      step(1'h0, 1'h0, 18'h00000);
      chk(dataOutEn === 1'h0, "drive off");
      outputEnable_n <= 1'h0;
      step(1'h0, 1'h0, 18'h00000);
      chk(dataOutEn === 1'h1, "drive on");
      $display("test output enable done");
      device_reset_n <= 1'h0;
      clearModel;
      step(1'h0, 1'h0, 18'h00000);
      device_reset_n <= 1'h1;
      for (i = 0; i < 5; i++) step(1'h1, 1'h0, 18'($urandom));
      for (i = 0; i < 2; i++) step(1'h0, 1'h1, 18'h00000);
      retransmit_strobe <= 1'h1;
      rp = 0;
      lvl = wp;
      step(1'h0, 1'h0, 18'h00000);
      retransmit_strobe <= 1'h0;
      for (i = 0; i < 5; i++) step(1'h0, 1'h1, 18'h00000);
      $display("test retransmit done");
      offset_access_select <= 1'h0;
      step(1'h1, 1'h0, 18'h00003);
      step(1'h1, 1'h0, 18'h00005);
      step(1'h0, 1'h1, 18'h00000);
      chk(dataOut[11:0] === 12'h003, "ae offset");
      step(1'h0, 1'h1, 18'h00000);
      chk(dataOut[11:0] === 12'h005, "af offset");
      offset_access_select <= 1'h1;
      aeOfs = 3;
      afOfs = 5;
      for (i = 0; i < 5; i++) step(1'h1, 1'h0, 18'($urandom));
      step(1'h0, 1'h0, 18'h00000);
      $display("test offsets done");
      ahb(1'h0, 8'h08, 32'h00000000);
      chk(rd === 32'h00050003, "offset view");
      ahb(1'h0, 8'h04, 32'h00000000);
      chk(rd[4:0] === expFlags(lvl), "status flags");
      chk(rd[31:16] === 16'(lvl), "status level");
      ahb(1'h1, 8'h00, 32'h00000001);
      ahb(1'h0, 8'h00, 32'h00000000);
      chk(rd[1:0] === 2'h1, "ctrl readback");
      syncMode = 1'h1;
      for (i = 0; i < 4; i++) step(1'h0, 1'h1, 18'h00000);
      step(1'h0, 1'h0, 18'h00000);
      ahb(1'h1, 8'h00, 32'h00000000);
      syncMode = 1'h0;
      ahb(1'h1, 8'h0C, 32'hFFFFFFFF);
      ahb(1'h0, 8'h0C, 32'h00000000);
      chk(rd === 32'h00000000, "unmapped");
      $display("test registers done");
      results;
   end
endmodule
`default_nettype wire
